// file: logic/main_crystal_osc_trim_and_ready_control.sv
// Crystal oscillator trim, start-up and settled interrupt control
`timescale 1ns/1ps

// Summary of operation
// - Eleven bit trim, zero is slowest
// - One trim register feeds both banks
// - Low eight bits drive binary caps
// - Top three bits become thermometer code
// - Down-counter from start value, irq at one
// - Counter ticks slow RC or sleep clock
// - Hardware enables oscillator by itself
// - Start-up ends on amplitude or count
// - Trim applied in one step at end
// - Amplitude rise snapshots counter value
// - Done flag, cleared on power-down in modes 00/01 only
// - Divider keeps divided line at sixteen
// - Sleep clock only from three sources
// - System clock from any allowed source
// - Fast RC clocks logic while settling
module main_crystal_osc_trim_and_ready_control
	import xtal_trim_pkg::*;
(
	input  wire logic                   clk,
	input  wire logic                   rst,
	input  wire reg_req_t               req,
	output logic [`XT_DW-1:0]           rdata,
	input  wire logic                   power_up_req,
	input  wire logic                   wake_req,
	input  wire logic                   sys_pd,
	input  wire logic                   osc_amplitude_ok,
	input  wire logic                   slow_rc_osc,
	input  wire logic                   sleep_clk,
	input  wire logic                   main_crystal_osc,
	output logic                        osc_enable,
	output cap_bank_t                   bank_a,
	output cap_bank_t                   bank_b,
	output logic                        osc_settled_irq_line,
	output sys_src_t                    sys_src,
	output lp_src_t                     low_power_clock,
	output logic [2:0]                  divn_ratio,
	output logic                        cpu_on_fast_rc
);

	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	seq_state_t               state;          // Sequencer
	seq_state_t               next_state;
	logic [`XT_TRIM_W-1:0]    crystal_trim_code;
	logic [`XT_CNT_W-1:0]     settle_count_start_reg;
	logic [1:0]               trim_sel;       // Start-up end mode
	logic [`XT_XCNT_W-1:0]    xtal_count_n;   // Crystal cycles
	logic [`XT_CNT_W-1:0]     settle_counter_value;
	logic [`XT_CNT_W-1:0]     settle_count_snapshot;
	logic [`XT_XCNT_W-1:0]    xcnt;           // Crystal edge count
	logic                     trim_done_flag;
	logic [`XT_IRQ_W-1:0]     irq_stat;       // Sticky events
	logic [`XT_IRQ_W-1:0]     irq_mask;
	logic                     from_wake;      // Sleep clock counts
	cap_bank_t                bank;           // Single bank source
	logic                     slow_q;         // Edge history
	logic                     sleep_q;
	logic                     xtal_q;
	logic                     ok_q;
	sys_src_t                 sys_sel;        // Software choice

	// ------------------------------------------------------------
	// Decoding
	// ------------------------------------------------------------
	// Thermometer decode of the top trim bits
	function automatic logic [`XT_THERM_W-1:0] therm_dec(
		input logic [2:0] v
	);
		logic [`XT_THERM_W-1:0] t;
		t = '0;
		t[0] = 1'b1;
		for (int i = 1; i < `XT_THERM_W; i++) begin
			t[i] = (v > 3'(i));
		end
		return t;
	endfunction

	// Address match, used for writes; reads decode req.addr in a case
	function automatic logic hit(
		input logic [`XT_AW-1:0] a,
		input logic [`XT_AW-1:0] ofs
	);
		return a == ofs;
	endfunction

	wire wr_trim  = req.wr && hit(req.addr, `XT_OFS_TRIM);
	wire wr_start = req.wr && hit(req.addr, `XT_OFS_START);
	wire wr_tctrl = req.wr && hit(req.addr, `XT_OFS_TCTRL);
	wire wr_istat = req.wr && hit(req.addr, `XT_OFS_ISTAT);
	wire wr_imask = req.wr && hit(req.addr, `XT_OFS_IMASK);
	wire wr_csel  = req.wr && hit(req.addr, `XT_OFS_CSEL);

	// Clock-select write fields; illegal codes are dropped
	wire [2:0] csel_sys = req.wdata[2:0];
	wire [1:0] csel_lp  = req.wdata[`XT_CS_LP_MSB:`XT_CS_LP_LSB];
	wire       lp_ok    = csel_lp != 2'h3;
	wire       sys_ok   = csel_sys != 3'h7;

	// Tick edges of the slow inputs; sampled as synchronous
	wire slow_tick  = slow_rc_osc && !slow_q;
	wire sleep_tick = sleep_clk && !sleep_q;
	wire xtal_tick  = main_crystal_osc && !xtal_q;
	wire ok_rise    = osc_amplitude_ok && !ok_q;

	// counter clock choice by start kind
	wire cnt_tick   = from_wake ? sleep_tick : slow_tick;

	wire starting   = (state == ST_IDLE) && (power_up_req || wake_req);
	wire counting   = (state == ST_STARTUP) || (state == ST_SETTLE);
	// fires when the counter is down to one
	wire settle_hit = counting && (settle_counter_value <= 16'h0001);

	// end of start-up by amplitude or count
	wire digital_end = trim_sel[0] ? (xcnt >= xtal_count_n)
	                               : osc_amplitude_ok;
	wire startup_end = (state == ST_STARTUP) &&
	                   (digital_end || settle_hit);

	// power-down clears done only in 00/01
	wire done_clr   = sys_pd && !trim_sel[1];

	wire [`XT_IRQ_W-1:0] irq_set = {startup_end, settle_hit};
	wire [`XT_IRQ_W-1:0] irq_clr = wr_istat ?
	                               req.wdata[`XT_IRQ_W-1:0] : '0;

	// divider to keep the divided line at 16 MHz
	wire [2:0] next_ratio = (sys_src == SYS_PLL) ? `XT_PLL_RATIO
	                                            : `XT_ONE_RATIO;

	// fast RC stands in while the crystal settles
	wire fast_rc_hold = (state != ST_READY) && (state != ST_IDLE ||
	                   starting);

	// ------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------
	// Next state of the start-up sequence
	always_comb begin
		next_state = state;
		case (state)
			ST_IDLE: begin
				if (starting)
					next_state = ST_STARTUP;
			end
			ST_STARTUP: begin
				if (settle_hit)
					next_state = ST_READY;
				else if (startup_end)
					next_state = ST_SETTLE;
			end
			ST_SETTLE: begin
				if (settle_hit)
					next_state = ST_READY;
			end
			ST_READY: begin
				next_state = ST_READY;
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
		// Power-down of the system domain stops everything
		if (sys_pd)
			next_state = ST_IDLE;
	end

	// State register
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			state <= ST_IDLE;
		else
			state <= next_state;
	end

	// Oscillator enable follows the sequence
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			osc_enable <= 1'b0;
		else if (sys_pd)
			osc_enable <= 1'b0;
		else if (starting)
			osc_enable <= 1'b1;
	end

	// Remember whether this start is a wake-up
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			from_wake <= 1'b0;
		else if (starting)
			from_wake <= wake_req && !power_up_req;
	end

	// ------------------------------------------------------------
	// Counters
	// ------------------------------------------------------------
	// Settled down-counter; holds at one until the next start
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			settle_counter_value <= '0;
		else if (starting)
			settle_counter_value <= settle_count_start_reg;
		else if (counting && cnt_tick && !settle_hit)
			settle_counter_value <= settle_counter_value - 16'h0001;
	end

	// Crystal cycle counter for the digital start-up end
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			xcnt <= '0;
		else if (starting)
			xcnt <= '0;
		// count crystal edges while starting up
		else if (state == ST_STARTUP && xtal_tick && !(&xcnt))
			xcnt <= xcnt + 12'h001;
	end

	// Edge history of the sampled inputs
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			slow_q  <= 1'b0;
			sleep_q <= 1'b0;
			xtal_q  <= 1'b0;
			ok_q    <= 1'b0;
		end else begin
			slow_q  <= slow_rc_osc;
			sleep_q <= sleep_clk;
			xtal_q  <= main_crystal_osc;
			ok_q    <= osc_amplitude_ok;
		end
	end

	// Snapshot only on amplitude rise or reset, never by software
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			settle_count_snapshot <= '0;
		else if (ok_rise)
			settle_count_snapshot <= settle_counter_value;
	end

	// ------------------------------------------------------------
	// Trim application
	// ------------------------------------------------------------
	// Banks change once, at the end of start-up
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			bank <= '0;
		// single step apply in both modes
		end else if (startup_end) begin
			bank.bin   <= crystal_trim_code[`XT_BIN_W-1:0];
			// thermometer part from the top bits
			bank.therm <= therm_dec(crystal_trim_code[10:8]);
		end
	end

	// both banks come from the same register
	assign bank_a = bank;
	assign bank_b = bank;

	// Done flag; set wins over a coincident clear
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			trim_done_flag <= 1'b0;
		// set on apply, clear on power-down in modes 00/01
		else if (startup_end)
			trim_done_flag <= 1'b1;
		else if (done_clr)
			trim_done_flag <= 1'b0;
	end

	// ------------------------------------------------------------
	// Register file
	// ------------------------------------------------------------
	// Software writable control registers
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			crystal_trim_code      <= `XT_TRIM_RST;
			settle_count_start_reg <= `XT_START_RST;
			trim_sel               <= '0;
			xtal_count_n           <= `XT_XCNT_RST;
			irq_mask               <= '0;
		end else begin
			if (wr_trim)
				crystal_trim_code <= req.wdata[`XT_TRIM_W-1:0];
			if (wr_start)
				settle_count_start_reg <= req.wdata[`XT_CNT_W-1:0];
			if (wr_tctrl) begin
				trim_sel     <= req.wdata[`XT_TC_SEL_MSB:0];
				xtal_count_n <=
					req.wdata[`XT_TC_CNT_MSB:`XT_TC_CNT_LSB];
			end
			if (wr_imask)
				irq_mask <= req.wdata[`XT_IRQ_W-1:0];
		end
	end

	// Clock source selection
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sys_sel         <= SYS_FAST_RC;
			low_power_clock <= LP_SLOW_RC;
		end else if (wr_csel) begin
			if (sys_ok)
				sys_sel <= sys_src_t'(csel_sys);
			if (lp_ok)
				low_power_clock <= lp_src_t'(csel_lp);
		end
	end

	// Effective source and divider, registered
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sys_src        <= SYS_FAST_RC;
			cpu_on_fast_rc <= 1'b1;
			divn_ratio     <= `XT_ONE_RATIO;
		end else begin
			// fast RC during power-up or wake
			cpu_on_fast_rc <= fast_rc_hold;
			sys_src        <= fast_rc_hold ? SYS_FAST_RC : sys_sel;
			divn_ratio     <= next_ratio;
		end
	end

	// Sticky events, write one to clear, set wins
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			irq_stat <= '0;
		else
			irq_stat <= (irq_stat & ~irq_clr) | irq_set;
	end

	// Level interrupt, high while an unmasked bit is set
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			osc_settled_irq_line <= 1'b0;
		else
			osc_settled_irq_line <=
				|(((irq_stat & ~irq_clr) | irq_set) & irq_mask);
	end

	// Read data one cycle after the strobe; unmapped reads zero
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			rdata <= '0;
		else if (req.rd) begin
			case (req.addr)
				`XT_OFS_TRIM:  rdata <= 32'(crystal_trim_code);
				`XT_OFS_START: rdata <= 32'(settle_count_start_reg);
				`XT_OFS_TCTRL: rdata <= 32'({xtal_count_n, 2'b00,
				                             trim_sel});
				`XT_OFS_SNAP:  rdata <= 32'(settle_count_snapshot);
				`XT_OFS_STAT:  rdata <= {settle_counter_value,
				                         8'h00, state, 3'b000,
				                         trim_done_flag};
				`XT_OFS_ISTAT: rdata <= 32'(irq_stat);
				`XT_OFS_IMASK: rdata <= 32'(irq_mask);
				`XT_OFS_CSEL:  rdata <= 32'({low_power_clock,
				                             1'b0, sys_sel});
				default:       rdata <= '0;
			endcase
		end else
			rdata <= '0;
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	a_bank_therm_map: assert property (
		$past(startup_end) |-> bank.therm ==
		therm_dec($past(crystal_trim_code[10:8])))
		else $error("thermometer bank mismatch");
	a_bank_bin_map: assert property (
		startup_end |=> bank.bin == $past(crystal_trim_code[7:0]))
		else $error("binary bank mismatch");
	a_banks_equal: assert property (
		bank_a == bank_b) else $error("banks differ");
	a_bank_hold: assert property (
		!startup_end |=> $stable(bank))
		else $error("bank changed outside start-up end");
	a_count_load: assert property (
		starting |=> settle_counter_value ==
		$past(settle_count_start_reg))
		else $error("counter not loaded");
	a_irq_at_one: assert property (
		settle_hit |=> irq_stat[`XT_IRQ_SETTLE])
		else $error("settled event lost");
	a_osc_auto_on: assert property (
		starting && !sys_pd |=> osc_enable)
		else $error("oscillator not enabled");
	a_snap_capture: assert property (
		ok_rise |=> settle_count_snapshot ==
		$past(settle_counter_value))
		else $error("snapshot missed");
	a_snap_hold: assert property (
		!ok_rise |=> $stable(settle_count_snapshot))
		else $error("snapshot moved");
	a_done_clear: assert property (
		done_clr && !startup_end |=> !trim_done_flag)
		else $error("done flag not cleared");
	a_done_keep: assert property (
		sys_pd && trim_sel[1] && trim_done_flag |=> trim_done_flag)
		else $error("done flag dropped in retain mode");
	a_lp_legal: assert property (
		low_power_clock != lp_src_t'(2'h3))
		else $error("illegal sleep clock");
	a_fast_rc_start: assert property (
		starting |=> cpu_on_fast_rc ##1 sys_src == SYS_FAST_RC)
		else $error("not on fast RC while starting");
	a_tick_source: assert property (
		counting && !starting && !settle_hit && !cnt_tick |=>
		$stable(settle_counter_value))
		else $error("counter moved without its tick");

	c_power_up: cover property (
		power_up_req && starting ##[1:200] settle_hit);
	c_wake_up: cover property (
		wake_req && starting ##[1:200] settle_hit);
	c_digital_end: cover property (
		startup_end && trim_sel[0] && !settle_hit);
	c_irq_out: cover property (osc_settled_irq_line);

endmodule

// file: logic/xtal_trim_regs.svh
// Register map, field layout, reset values and widths of the trim block
`ifndef XTAL_TRIM_REGS_SVH
`define XTAL_TRIM_REGS_SVH

// ------------------------------------------------------------
// Widths
// ------------------------------------------------------------
`define XT_AW         5
`define XT_DW         32
`define XT_TRIM_W     11
`define XT_BIN_W      8
`define XT_THERM_W    7
`define XT_CNT_W      16
`define XT_XCNT_W     12
`define XT_IRQ_W      2

// ------------------------------------------------------------
// Register offsets (byte addresses)
// ------------------------------------------------------------
`define XT_OFS_TRIM   5'h00
`define XT_OFS_START  5'h04
`define XT_OFS_TCTRL  5'h08
`define XT_OFS_SNAP   5'h0c
`define XT_OFS_STAT   5'h10
`define XT_OFS_ISTAT  5'h14
`define XT_OFS_IMASK  5'h18
`define XT_OFS_CSEL   5'h1c

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define XT_TC_SEL_MSB 1
`define XT_TC_CNT_LSB 4
`define XT_TC_CNT_MSB 15
`define XT_CS_LP_LSB  4
`define XT_CS_LP_MSB  5
`define XT_IRQ_SETTLE 0
`define XT_IRQ_TRIM   1

// ------------------------------------------------------------
// Reset values and fixed codes
// ------------------------------------------------------------
`define XT_TRIM_RST   11'h400
`define XT_START_RST  16'h0100
`define XT_XCNT_RST   12'h100
`define XT_PLL_RATIO  3'h6
`define XT_ONE_RATIO  3'h1

`endif

// file: logic/xtal_trim_pkg.sv
// Types shared by the crystal trim and ready control block
`include "xtal_trim_regs.svh"
package xtal_trim_pkg;

	// Sequencer states, one-hot
	typedef enum logic [3:0] {
		ST_IDLE    = 4'h1,
		ST_STARTUP = 4'h2,
		ST_SETTLE  = 4'h4,
		ST_READY   = 4'h8
	} seq_state_t;

	// System clock sources
	typedef enum logic [2:0] {
		SYS_FAST_RC  = 3'h0,
		SYS_SLOW_RC  = 3'h1,
		SYS_ENH_RC   = 3'h2,
		SYS_SLEEP_XT = 3'h3,
		SYS_MAIN_XT  = 3'h4,
		SYS_PLL      = 3'h5,
		SYS_EXT      = 3'h6
	} sys_src_t;

	// Low power clock sources; code 3 is not a source
	typedef enum logic [1:0] {
		LP_ENH_RC   = 2'h0,
		LP_SLOW_RC  = 2'h1,
		LP_SLEEP_XT = 2'h2
	} lp_src_t;

	// Register port request
	typedef struct packed {
		logic [`XT_AW-1:0] addr;
		logic [`XT_DW-1:0] wdata;
		logic              wr;
		logic              rd;
	} reg_req_t;

	// Control word of one capacitor bank
	typedef struct packed {
		logic [`XT_THERM_W-1:0] therm;
		logic [`XT_BIN_W-1:0]   bin;
	} cap_bank_t;

endpackage

// file: bench/osc_core_model.sv
// Behavioural model of the crystal core and the two slow clocks
`timescale 1ns/1ps

module osc_core_model #(
	parameter int AMP_DLY = 40 // Cycles from enable to amplitude good
) (
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic osc_enable,
	input  wire logic amp_mute,
	input  wire logic run_slow,
	input  wire logic run_sleep,
	output logic      osc_amplitude_ok,
	output logic      main_crystal_osc,
	output logic      slow_rc_osc,
	output logic      sleep_clk
);
	logic [9:0] amp_cnt;   // Cycles since enable
	logic [2:0] slow_div;  // Slow RC divider, period 8
	logic [3:0] sleep_div; // Sleep clock divider, period 12

	// ------------------------------------------------------------
	// Crystal core
	// ------------------------------------------------------------
	// Amplitude and crystal edges
	// A stopped crystal stands low; muting lets count mode be proven
	always_ff @(posedge clk or posedge rst) begin
		if (rst || !osc_enable) begin
			amp_cnt <= '0;
			osc_amplitude_ok <= 1'b0;
			main_crystal_osc <= 1'b0;
		end else begin
			main_crystal_osc <= ~main_crystal_osc;
			if (amp_cnt != 10'h3ff) begin
				amp_cnt <= amp_cnt + 10'h001;
			end
			osc_amplitude_ok <= !amp_mute && (amp_cnt >= AMP_DLY[9:0]);
		end
	end

	// ------------------------------------------------------------
	// Slow clocks
	// ------------------------------------------------------------
	// Separate tick sources
	// A stopped source stands low so a wrong choice hangs the count
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			slow_div <= '0;
			sleep_div <= '0;
		end else begin
			slow_div <= run_slow ? slow_div + 3'h1 : 3'h0;
			sleep_div <= (!run_sleep || sleep_div == 4'hb) ? 4'h0
				: sleep_div + 4'h1;
		end
	end
	assign slow_rc_osc = run_slow & slow_div[2];
	assign sleep_clk = run_sleep & (sleep_div >= 4'h6);
endmodule

// file: bench/main_crystal_osc_trim_and_ready_control_tb_top.sv
// Self-checking bench of the crystal trim and ready control
`timescale 1ns/1ps
`include "xtal_trim_regs.svh"

module main_crystal_osc_trim_and_ready_control_tb_top
	import xtal_trim_pkg::*;
();
	logic              clk, rst, rd_seen;
	reg_req_t          req;
	logic [`XT_DW-1:0] rdata, last_rd, snap_prev;
	logic              power_up_req, wake_req, sys_pd;
	logic              osc_amplitude_ok, slow_rc_osc, sleep_clk;
	logic              main_crystal_osc, osc_enable, osc_settled_irq_line;
	logic              amp_mute, run_slow, run_sleep, cpu_on_fast_rc;
	cap_bank_t         bank_a, bank_b;
	sys_src_t          sys_src;
	lp_src_t           low_power_clock;
	logic [2:0]        divn_ratio;
	logic [31:0]       exp_q[$], msk_q[$]; // Pending read notes
	int                n_mismatch, n_tests, seed, cycles;

	main_crystal_osc_trim_and_ready_control u_main_crystal_osc_trim_and_ready_control (
		.clk(clk), .rst(rst), .req(req), .rdata(rdata),
		.power_up_req(power_up_req), .wake_req(wake_req), .sys_pd(sys_pd),
		.osc_amplitude_ok(osc_amplitude_ok), .slow_rc_osc(slow_rc_osc),
		.sleep_clk(sleep_clk), .main_crystal_osc(main_crystal_osc),
		.osc_enable(osc_enable), .bank_a(bank_a), .bank_b(bank_b),
		.osc_settled_irq_line(osc_settled_irq_line), .sys_src(sys_src),
		.low_power_clock(low_power_clock), .divn_ratio(divn_ratio),
		.cpu_on_fast_rc(cpu_on_fast_rc));

	osc_core_model u_osc_core_model (
		.clk(clk), .rst(rst), .osc_enable(osc_enable), .amp_mute(amp_mute),
		.run_slow(run_slow), .run_sleep(run_sleep),
		.osc_amplitude_ok(osc_amplitude_ok),
		.main_crystal_osc(main_crystal_osc), .slow_rc_osc(slow_rc_osc),
		.sleep_clk(sleep_clk));

	// Free-running system clock
	always #5 clk = ~clk;

	// ------------------------------------------------------------
	// Reporting
	// ------------------------------------------------------------
	task automatic cmp_rd(input logic [31:0] g, e, m);
		n_tests++;
		if ((g & m) !== (e & m)) begin
			n_mismatch++;
			$display("ERROR %0t read %h expected %h", $time, g, e);
		end
	endtask

	task automatic cmp_pin(input logic [31:0] g, e);
		n_tests++;
		if (g !== e) begin
			n_mismatch++;
			$display("ERROR %0t pin %h expected %h", $time, g, e);
		end
	endtask

	task automatic tally_and_finish();
		$display("tests %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// Read watcher takes the oldest note when data stands
	always @(posedge clk) begin
		if (rd_seen) begin
			last_rd = rdata;
			if (exp_q.size() == 0) begin
				cmp_rd(rdata, 32'hdead_beef, '1);
			end else begin
				cmp_rd(rdata, exp_q.pop_front(), msk_q.pop_front());
			end
		end
		rd_seen <= req.rd;
		cmp_pin({17'h0, bank_a}, {17'h0, bank_b});
	end

	// Hang guard, far above the expected run length
	always @(posedge clk) begin
		cycles++;
		if (cycles == 30000) begin
			n_mismatch++;
			$display("ERROR %0t run did not finish", $time);
			tally_and_finish();
		end
	end

	// ------------------------------------------------------------
	// Register bus
	// ------------------------------------------------------------
	// One strobe cycle, then one idle cycle
	task automatic bus(input logic w, r, input logic [`XT_AW-1:0] a,
		input logic [31:0] d);
		@(posedge clk);
		req <= '{addr: a, wdata: d, wr: w, rd: r};
		@(posedge clk);
		req <= '0;
	endtask

	task automatic wr(input logic [`XT_AW-1:0] a, input logic [31:0] d);
		bus(1'b1, 1'b0, a, d);
	endtask

	task automatic rd(input logic [`XT_AW-1:0] a, input logic [31:0] e, m);
		exp_q.push_back(e);
		msk_q.push_back(m);
		bus(1'b0, 1'b1, a, 32'h0);
	endtask

	// Waits past the watcher so last_rd is fresh
	task automatic settle();
		@(posedge clk);
		#1;
	endtask

	// ------------------------------------------------------------
	// One start sequence per top trim value
	// ------------------------------------------------------------
	task automatic run_seq(input logic [2:0] t);
		logic [10:0] code;
		logic [6:0]  therm;
		logic [1:0]  sel;
		cap_bank_t   prev;
		int          n;
		code[10:8] = t;
		code[7:0] = (t == 3'h0) ? 8'h00 : (t == 3'h7) ? 8'hff
			: 8'($random(seed));
		therm = (t == 3'h0) ? 7'h01 : 7'((8'h01 << t) - 8'h01);
		sel = t[1:0];
		prev = bank_a;
		amp_mute <= sel[0];
		run_slow <= ~t[2];
		run_sleep <= t[2];
		wr(`XT_OFS_TRIM, {21'h0, code});
		wr(`XT_OFS_START, 32'h0000_000c);
		wr(`XT_OFS_TCTRL, {16'h0, 12'h008, 2'b00, sel});
		@(posedge clk);
		// Wake from sleep on the upper half
		if (t[2]) begin
			wake_req <= 1'b1;
		end else begin
			power_up_req <= 1'b1;
		end
		@(posedge clk);
		power_up_req <= 1'b0;
		wake_req <= 1'b0;
		repeat (2) settle();
		cmp_pin({31'h0, osc_enable}, 32'h1);
		cmp_pin({31'h0, cpu_on_fast_rc}, 32'h1);
		cmp_pin({29'h0, sys_src}, {29'h0, SYS_FAST_RC});
		// Trim must land well before the counter could end start-up
		n = 0;
		while (bank_a === prev && n < 60) begin
			settle();
			n++;
		end
		cmp_pin({17'h0, bank_a}, {17'h0, therm, code[7:0]});
		n = 0;
		while (osc_settled_irq_line !== 1'b1 && n < 400) begin
			settle();
			n++;
		end
		cmp_pin({31'h0, osc_settled_irq_line}, 32'h1);
		rd(`XT_OFS_STAT, 32'h0001_0081, '1);
		rd(`XT_OFS_ISTAT, 32'h3, '1);
		rd(`XT_OFS_SNAP, 32'h0, 32'h0);
		settle();
		// Amplitude mode snapshots mid-count; count mode keeps old value
		if (!sel[0]) begin
			cmp_pin({31'h0, last_rd > 1 && last_rd <= 12}, 32'h1);
		end else begin
			cmp_pin(last_rd, snap_prev);
		end
		snap_prev = last_rd;
		// Back on the software choice SYS_EXT once the start sequence is over
		cmp_pin({28'h0, cpu_on_fast_rc, sys_src}, {29'h0, SYS_EXT});
		// The line follows a new mask one edge after the write
		wr(`XT_OFS_IMASK, 32'h0);
		settle();
		cmp_pin({31'h0, osc_settled_irq_line}, 32'h0);
		wr(`XT_OFS_IMASK, 32'h2);
		settle();
		cmp_pin({31'h0, osc_settled_irq_line}, 32'h1);
		wr(`XT_OFS_IMASK, 32'h1);
		wr(`XT_OFS_ISTAT, 32'h3);
		#1;
		cmp_pin({31'h0, osc_settled_irq_line}, 32'h0);
		rd(`XT_OFS_ISTAT, 32'h0, '1);
		@(posedge clk);
		sys_pd <= 1'b1;
		@(posedge clk);
		sys_pd <= 1'b0;
		settle();
		cmp_pin({31'h0, osc_enable}, 32'h0);
		rd(`XT_OFS_STAT, {27'h0, 1'b1, 3'h0, sel[1]}, 32'hff);
	endtask

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		logic [2:0] sx;
		logic [1:0] lx;
		clk = 1'b0;
		rst = 1'b1;
		req = '0;
		{power_up_req, wake_req, sys_pd, amp_mute, rd_seen} = '0;
		{run_slow, run_sleep} = 2'b11;
		{n_mismatch, n_tests, cycles} = '0;
		snap_prev = '0;
		seed = 39;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		settle();
		// Fast RC, slow RC sleep clock, ratio one, idle and disabled
		cmp_pin({22'h0, sys_src, low_power_clock, divn_ratio,
			cpu_on_fast_rc, osc_enable}, 32'h0000_0024);
		cmp_pin({16'h0, bank_a, osc_settled_irq_line}, 32'h0);
		rd(`XT_OFS_TRIM, 32'h400, '1);
		rd(`XT_OFS_START, 32'h100, '1);
		rd(`XT_OFS_TCTRL, 32'h1000, '1);
		rd(`XT_OFS_IMASK, 32'h0, '1);
		rd(`XT_OFS_STAT, 32'h10, 32'hff);
		wr(`XT_OFS_SNAP, 32'hffff);
		rd(`XT_OFS_SNAP, 32'h0, '1);
		rd(5'h03, 32'h0, '1);
		// Clock source codes; illegal codes leave the old choice
		sx = 3'h0;
		lx = 2'h1;
		for (int s = 0; s < 8; s++) begin
			wr(`XT_OFS_CSEL, {26'h0, 2'(s), 1'b0, 3'(s)});
			if (s != 7) begin
				sx = 3'(s);
			end
			if (s % 4 != 3) begin
				lx = 2'(s);
			end
			repeat (2) settle();
			cmp_pin({29'h0, sys_src}, {29'h0, sx});
			cmp_pin({30'h0, low_power_clock}, {30'h0, lx});
			cmp_pin({29'h0, divn_ratio}, (s == 5) ? 32'h6 : 32'h1);
		end
		rd(`XT_OFS_CSEL, 32'h26, 32'h37);
		wr(`XT_OFS_IMASK, 32'h1);
		for (int t = 0; t < 8; t++) begin
			run_seq(3'(t));
		end
		repeat (3) settle();
		tally_and_finish();
	end
endmodule
